// ---- core/sps_pkg.sv ----
/*
  Constants shared by the serial-port pin-role block: register offsets,
  field positions, reset values, select-pin modes and link-state codes.
  Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
// How it works
// - as master, the master-out line follows the shift register MSB
// - master-out line is driven as master, input as slave
// - master-in line is input as master, driven as slave
// - every byte moves most significant bit first, both directions
// - master-in floats when disabled or an unselected 4-wire slave
// - 3-wire slave always drives master-in from the shift register MSB
// - master makes and drives the serial clock; slave takes it in
// - 4-wire slave ignores serial clock edges while select is high
// - mode 00 is 3-wire, select unused, slave always selected
// - mode 01 makes select an input; low selects the slave
// - mode 01 master is disabled by a falling select input
// - mode 1x drives select as output at the mode low bit
// - select reaches a pin in every mode except 3-wire
// - done flag set at each finished transfer, both directions
// - multi-master fault clears master and port enables, sets fault flag
// - 4-wire slave clears its bit counter on each select fall
package sps_pkg;
  // bus and clock
  localparam int AXI_AW = 8;
  localparam int CLK_MHZ = 125;
  localparam int SYNC_STAGES = 2;
  localparam int SEL_SETUP_CLKS = 2; // external master's select lead

  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] DATA_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [7:0] CLR_OFF = 8'h0C;
  localparam logic [7:0] IEN_OFF = 8'h10;
  localparam logic [7:0] DIV_OFF = 8'h14;

  // control register fields
  localparam int CTRL_EN_BIT = 0;   // port_enable_bit
  localparam int CTRL_MST_BIT = 1;  // master_enable_bit
  localparam int CTRL_MODE_LSB = 2; // select_pin_mode, two bits
  localparam int CTRL_BUSY_BIT = 4; // read only

  // status, clear and enable layout
  localparam int ST_DONE = 0;  // transfer_done_flag
  localparam int ST_FAULT = 1; // mode_fault_flag
  localparam int ST_WCOL = 2;  // write while shifting
  localparam int ST_OVR = 3;   // slave byte lost to unread buffer
  localparam int ST_W = 4;

  // reset values
  localparam logic [1:0] MODE_RST = 2'h1;
  localparam logic [7:0] DIV_RST = 8'h03;
  localparam logic [3:0] IEN_RST = 4'h0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // select_pin_mode encodings
  localparam logic [1:0] MODE_3W = 2'h0;
  localparam logic [1:0] MODE_4W_IN = 2'h1;
  localparam int MODE_HI_BIT = 1; // select_mode_high_bit
  localparam int MODE_LO_BIT = 0; // select_mode_low_bit

  localparam logic [2:0] LAST_BIT = 3'h7;

  // master clock generator states
  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_LOW = 3'b010,
    M_HIGH = 3'b100
  } sps_mstate_e;
endpackage

// ---- core/sps_sync.sv ----
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes each bit is an independent level; reset value is a parameter.
*/
`timescale 1ns/1ps
module sps_sync
  import sps_pkg::*;
#(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // async levels in, synced levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// ---- core/sps_core.sv ----
/*
  Serial port unit: master/slave byte shifter with pin roles, select
  modes, mode-fault detection and an AXI4-Lite register slave.
  Assumes the pin wrapper resolves each line from its output enable,
  and that an external serial clock is slower than four system clocks
  per phase (two are lost in synchronising).
*/
`timescale 1ns/1ps
module sps_core
  import sps_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // serial clock pin
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  // master-out slave-in pin
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_out,
  // master-in slave-out pin
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_out,
  // slave select pin
  input wire logic slave_select_n_in,
  output logic slave_select_n_out,
  output logic slave_select_n_oe_out,
  output logic select_routed_out,
  // interrupt
  output logic irq_out
);
  // synchronised pins
  logic [3:0] pins_s;
  logic sck_s, mosi_s, miso_s, nss_s;

  sps_sync #(.WIDTH(4), .RST_VAL(4'h1)) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in({sck_in, mosi_in, miso_in, slave_select_n_in}),
    .sync_out(pins_s)
  );
  assign {sck_s, mosi_s, miso_s, nss_s} = pins_s;

  // bus slave state
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [AXI_AW-1:0] aw_addr_q, aw_addr_d;
  logic [7:0] w_data_q, w_data_d;
  logic w_lane_q, w_lane_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_fire, rd_fire;

  // core state
  logic en_q, en_d, mst_q, mst_d;
  logic [1:0] mode_q, mode_d;
  logic [7:0] div_q, div_d, divcnt_q, divcnt_d;
  logic [ST_W-1:0] stat_q, stat_d, ien_q, ien_d;
  logic [7:0] shift_q, shift_d, rx_q, rx_d;
  logic samp_q, samp_d, sck_q, sck_d;
  logic [2:0] cnt_q, cnt_d;
  logic rxfull_q, rxfull_d, skip_q, skip_d;
  logic sck_prev_q, nss_prev_q;
  sps_mstate_e state_q, state_d;

  // derived conditions
  logic selected, sck_rise, sck_fall, nss_fall, busy;
  logic [7:0] byte_in;
  logic [ST_W-1:0] ev, clr;

  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready = !w_full_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // bus slave: address and data may arrive in either order
  always_comb begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d = w_full_q;
    w_data_d = w_data_q;
    w_lane_d = w_lane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && !aw_full_q) begin
      aw_full_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_q) begin
      w_full_d = 1'b1;
      w_data_d = s_axi_wdata[7:0];
      w_lane_d = s_axi_wstrb[0];
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      case (aw_addr_q)
        CTRL_OFF, DATA_OFF, CLR_OFF, IEN_OFF, DIV_OFF: bresp_d = AXI_OKAY;
        default: bresp_d = AXI_SLVERR;
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (rd_fire) begin
      rvalid_d = 1'b1;
      rresp_d = AXI_OKAY;
      rdata_d = 32'h0;
      case (s_axi_araddr)
        CTRL_OFF: begin
          rdata_d[CTRL_EN_BIT] = en_q;
          rdata_d[CTRL_MST_BIT] = mst_q;
          rdata_d[CTRL_MODE_LSB +: 2] = mode_q;
          rdata_d[CTRL_BUSY_BIT] = busy;
        end
        DATA_OFF: rdata_d[7:0] = rx_q;
        STAT_OFF: rdata_d[ST_W-1:0] = stat_q;
        CLR_OFF: rdata_d = 32'h0; // write-only, reads zero
        IEN_OFF: rdata_d[ST_W-1:0] = ien_q;
        DIV_OFF: rdata_d[7:0] = div_q;
        default: rresp_d = AXI_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= AXI_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= AXI_OKAY;
      rdata_q <= 32'h0;
    end else begin
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q <= w_full_d;
      w_data_q <= w_data_d;
      w_lane_q <= w_lane_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // selection and edge detection on synced pins
  assign selected = (mode_q == MODE_3W) || // always selected
                    (mode_q == MODE_4W_IN && !nss_s);
  assign sck_rise = sck_s && !sck_prev_q;
  assign sck_fall = !sck_s && sck_prev_q;
  assign nss_fall = nss_prev_q && !nss_s;
  assign busy = (state_q != M_IDLE) || (cnt_q != 3'h0);
  assign clr = (wr_fire && w_lane_q && aw_addr_q == CLR_OFF) ?
               w_data_q[ST_W-1:0] : '0;

  // shifter, clock generator and register effects
  always_comb begin
    en_d = en_q;
    mst_d = mst_q;
    mode_d = mode_q;
    div_d = div_q;
    ien_d = ien_q;
    shift_d = shift_q;
    rx_d = rx_q;
    samp_d = samp_q;
    sck_d = sck_q;
    cnt_d = cnt_q;
    divcnt_d = divcnt_q;
    rxfull_d = rxfull_q;
    skip_d = skip_q;
    state_d = state_q;
    ev = '0;
    byte_in = 8'h00;
    // reading the data word frees the receive buffer
    if (rd_fire && s_axi_araddr == DATA_OFF) begin
      rxfull_d = 1'b0;
    end
    if (en_q && mst_q) begin
      case (state_q)
        M_IDLE: begin
          sck_d = 1'b0;
        end
        M_LOW: begin
          if (divcnt_q == div_q) begin
            divcnt_d = 8'h00;
            sck_d = 1'b1;
            samp_d = miso_s; // master samples master-in
            state_d = M_HIGH;
          end else begin
            divcnt_d = divcnt_q + 8'h01;
          end
        end
        M_HIGH: begin
          if (divcnt_q == div_q) begin
            divcnt_d = 8'h00;
            sck_d = 1'b0;
            byte_in = {shift_q[6:0], samp_q};
            shift_d = byte_in; // msb leaves first
            if (cnt_q == LAST_BIT) begin
              cnt_d = 3'h0;
              rx_d = byte_in;
              rxfull_d = 1'b1;
              ev[ST_DONE] = 1'b1;
              state_d = M_IDLE;
            end else begin
              cnt_d = cnt_q + 3'h1;
              state_d = M_LOW;
            end
          end else begin
            divcnt_d = divcnt_q + 8'h01;
          end
        end
        default: state_d = M_IDLE;
      endcase
    end else if (en_q && selected) begin
      // slave: clock edges count only while selected
      state_d = M_IDLE;
      sck_d = 1'b0;
      if (sck_rise) begin
        samp_d = mosi_s;
        if (cnt_q == LAST_BIT) begin
          cnt_d = 3'h0;
          byte_in = {shift_q[6:0], mosi_s};
          shift_d = byte_in;
          skip_d = 1'b1; // hold the byte past the trailing fall
          ev[ST_DONE] = 1'b1;
          if (rxfull_q) begin
            ev[ST_OVR] = 1'b1; // newest byte is dropped
          end else begin
            rx_d = byte_in;
            rxfull_d = 1'b1;
          end
        end else begin
          cnt_d = cnt_q + 3'h1;
        end
      end
      if (sck_fall) begin
        if (skip_q) begin
          skip_d = 1'b0;
        end else begin
          shift_d = {shift_q[6:0], samp_q};
        end
      end
    end else if (!en_q) begin
      // disabling is the only way to realign a 3-wire slave
      state_d = M_IDLE;
      sck_d = 1'b0;
      cnt_d = 3'h0;
      divcnt_d = 8'h00;
      skip_d = 1'b0;
    end
    // select fall realigns a 4-wire slave byte
    if (!mst_q && mode_q == MODE_4W_IN && nss_fall) begin
      cnt_d = 3'h0;
      skip_d = 1'b0;
    end
    // register writes
    if (wr_fire && w_lane_q) begin
      case (aw_addr_q)
        CTRL_OFF: begin
          en_d = w_data_q[CTRL_EN_BIT];
          mst_d = w_data_q[CTRL_MST_BIT];
          mode_d = w_data_q[CTRL_MODE_LSB +: 2];
        end
        DATA_OFF: begin
          if (busy || (state_d != M_IDLE)) begin
            ev[ST_WCOL] = 1'b1; // write ignored mid-byte
          end else begin
            shift_d = w_data_q;
            if (en_q && mst_q) begin
              state_d = M_LOW;
              divcnt_d = 8'h00;
            end
          end
        end
        IEN_OFF: ien_d = w_data_q[ST_W-1:0];
        DIV_OFF: div_d = w_data_q;
        default: ;
      endcase
    end
    // another master took the bus: fault wins over any write
    if (en_q && mst_q && mode_q == MODE_4W_IN && nss_fall) begin
      en_d = 1'b0;
      mst_d = 1'b0;
      ev[ST_FAULT] = 1'b1;
      state_d = M_IDLE;
      sck_d = 1'b0;
      cnt_d = 3'h0;
    end
  end

  // sticky flags: a new event outlasts a same-cycle clear
  assign stat_d = (stat_q & ~clr) | ev;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      en_q <= 1'b0;
      mst_q <= 1'b0;
      mode_q <= MODE_RST;
      div_q <= DIV_RST;
      ien_q <= IEN_RST;
      stat_q <= '0;
      shift_q <= 8'h00;
      rx_q <= 8'h00;
      samp_q <= 1'b0;
      sck_q <= 1'b0;
      cnt_q <= 3'h0;
      divcnt_q <= 8'h00;
      rxfull_q <= 1'b0;
      skip_q <= 1'b0;
      state_q <= M_IDLE;
      sck_prev_q <= 1'b0;
      nss_prev_q <= 1'b1;
    end else begin
      en_q <= en_d;
      mst_q <= mst_d;
      mode_q <= mode_d;
      div_q <= div_d;
      ien_q <= ien_d;
      stat_q <= stat_d;
      shift_q <= shift_d;
      rx_q <= rx_d;
      samp_q <= samp_d;
      sck_q <= sck_d;
      cnt_q <= cnt_d;
      divcnt_q <= divcnt_d;
      rxfull_q <= rxfull_d;
      skip_q <= skip_d;
      state_q <= state_d;
      sck_prev_q <= sck_s;
      nss_prev_q <= nss_s;
    end
  end

  // pin roles
  assign sck_out = sck_q;
  assign sck_oe_out = en_q && mst_q;
  assign mosi_out = shift_q[7];
  assign mosi_oe_out = en_q && mst_q;
  assign miso_out = shift_q[7];
  assign miso_oe_out = en_q && !mst_q && selected;
  assign slave_select_n_out = mode_q[MODE_LO_BIT];
  assign slave_select_n_oe_out = mode_q[MODE_HI_BIT];
  assign select_routed_out = (mode_q != MODE_3W);
  assign irq_out = |(stat_q & ien_q);
endmodule

// ---- tb/sps_core_properties.sv ----
/*
  Concurrent checks on the pin roles, select modes and bus holds of
  sps_core. Assumes it is bound to sps_core and sees only its ports.
*/
`timescale 1ns/1ps
module sps_core_properties (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic sck_out,
  input wire logic sck_oe_out,
  input wire logic mosi_out,
  input wire logic mosi_oe_out,
  input wire logic miso_oe_out,
  input wire logic slave_select_n_in,
  input wire logic slave_select_n_oe_out,
  input wire logic select_routed_out
);
  logic [2:0] sel_hi_q;
  logic [2:0] sel_hi_d;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // saturating count of a quiet select, covers the sync delay
  always_comb begin
    sel_hi_d = 3'h0;
    if (slave_select_n_in) begin
      sel_hi_d = (sel_hi_q == 3'h7) ? sel_hi_q : sel_hi_q + 3'h1;
    end
  end

  // register the count
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sel_hi_q <= 3'h0;
    end else begin
      sel_hi_q <= sel_hi_d;
    end
  end

  // pin role, route and bus hold checks
  chk_master_role: assert property (sck_oe_out == mosi_oe_out)
    else $error("clock and data out drive differ");
  chk_slave_role: assert property (
    miso_oe_out |-> !mosi_oe_out && !sck_oe_out)
    else $error("slave drives master lines");
  chk_route_out: assert property (
    slave_select_n_oe_out |-> select_routed_out)
    else $error("select driven but not routed");
  chk_mosi_hold: assert property (
    sck_out && mosi_oe_out |-> $stable(mosi_out))
    else $error("data out moved while clock high");
  chk_fault_drop: assert property (
    $fell(slave_select_n_in) && mosi_oe_out && select_routed_out &&
    !slave_select_n_oe_out |-> ##[1:6] !mosi_oe_out)
    else $error("master kept driving after select fall");
  chk_unsel_float: assert property (
    sel_hi_q == 3'h7 && select_routed_out && !slave_select_n_oe_out
    |-> !miso_oe_out)
    else $error("unselected slave drives master-in");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");

  // main scenarios reached
  cov_fault: cover property ($fell(mosi_oe_out));
  cov_slave: cover property ($rose(miso_oe_out));
  cov_sel_out: cover property (slave_select_n_oe_out);
endmodule

// ---- tb/sps_far_end.sv ----
/*
  Far-side spi parties: a mode 0 slave answering the device master and
  a master task with a 64 ns link clock. Assumes the bench resolves pins.
*/
`timescale 1ns/1ps
module sps_far_end (
  // resolved pin levels
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic miso_in,
  // far-side drives
  output logic sck_out,
  output logic mosi_out,
  output logic miso_out,
  output logic sel_n_out
);
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  initial begin
    sck_out = 1'b0;
    mosi_out = 1'b0;
    sel_n_out = 1'b1;
    tx_q = 8'h00;
    rx_q = 8'h00;
  end

  // slave: sample on rise, move on fall, msb first
  always @(posedge sck_in) rx_q = {rx_q[6:0], mosi_in};
  always @(negedge sck_in) tx_q = {tx_q[6:0], 1'b0};
  assign miso_out = tx_q[7];

  task automatic load(input logic [7:0] b);
    tx_q = b;
  endtask

  // select then wait, more than two system clocks of lead
  task automatic select(input logic lvl);
    sel_n_out = lvl;
    #40;
  endtask

  // master: clock stands low outside frames, msb first
  task automatic xfer(input logic [7:0] tx, input int nbits,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      mosi_out = tx[i];
      #32;
      sck_out = 1'b1;
      rx = {rx[6:0], miso_in};
      #32;
      sck_out = 1'b0;
    end
    #32; // last fall must land while the slave is still selected
    mosi_out = ~mosi_out; // released line must not echo a stale bit
  endtask
endmodule

// ---- tb/spi_pin_role_and_select_modes_test.sv ----
/*
  Bench for sps_core: axi4-lite master tasks, far-end model, scenarios.
  Assumes sps_pkg offsets and a free-standing 8 ns system clock.
*/
`timescale 1ns/1ps
module spi_pin_role_and_select_modes_test
  import sps_pkg::*;
;
  logic clk_in, reset_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq_out;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rx;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, bresp_seen;
  logic sck_out, sck_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out;
  logic slave_select_n_out, slave_select_n_oe_out, select_routed_out;
  logic far_sck, far_mosi, far_miso, far_sel_n;
  wire sck_in, mosi_in, miso_in, slave_select_n_in;
  int mismatches, total_checks, cycles;

  // each line takes whichever party enables its drive
  assign sck_in = sck_oe_out ? sck_out : far_sck;
  assign mosi_in = mosi_oe_out ? mosi_out : far_mosi;
  assign miso_in = miso_oe_out ? miso_out : far_miso;
  assign slave_select_n_in = slave_select_n_oe_out ? slave_select_n_out
                                                   : far_sel_n;

  sps_core dut_u (.clk_in, .reset_in, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .sck_in, .sck_out,
    .sck_oe_out, .mosi_in, .mosi_out, .mosi_oe_out, .miso_in, .miso_out,
    .miso_oe_out, .slave_select_n_in, .slave_select_n_out,
    .slave_select_n_oe_out, .select_routed_out, .irq_out);

  sps_far_end far_u (.sck_in(sck_in), .mosi_in(mosi_in), .miso_in(miso_in),
    .sck_out(far_sck), .mosi_out(far_mosi), .miso_out(far_miso),
    .sel_n_out(far_sel_n));

  always #4 clk_in = ~clk_in;

  // hang guard, far above the longest scenario
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  // ready sampled at the negedge before the edge that takes the item
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int n = 0; n < 100 && !b_t; n++) begin
      @(negedge clk_in);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      bresp_seen = s_axi_bresp;
      @(posedge clk_in);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk("write_answer", b_t, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    logic ar_t, r_t;
    r_t = 1'b0;
    @(posedge clk_in);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int n = 0; n < 100 && !r_t; n++) begin
      @(negedge clk_in);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk_in);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk("read_answer", r_t, 1'b1);
  endtask

  task automatic wait_done(output logic [31:0] s);
    logic [1:0] rs;
    s = '0;
    for (int n = 0; n < 200 && !s[ST_DONE]; n++) rd(STAT_OFF, s, rs);
  endtask

  task automatic t_reset();
    rd(CTRL_OFF, d, r);
    chk("ctrl_reset", d, 32'h00000004);
    chk("miso_oe_idle", miso_oe_out, 1'b0);
    chk("routed_reset", select_routed_out, 1'b1);
    rd(8'h18, d, r);
    chk("unmapped_resp", r, AXI_SLVERR);
    wr(8'h18, 32'h00000000);
    chk("unmapped_wresp", bresp_seen, AXI_SLVERR);
    // a write with lane 0 off must leave the control word alone
    s_axi_wstrb <= 4'h0;
    wr(CTRL_OFF, 32'h00000003);
    s_axi_wstrb <= 4'hF;
    rd(CTRL_OFF, d, r);
    chk("strb_gated", d, 32'h00000004);
  endtask

  // 3-wire master byte, a colliding write, then the interrupt path
  task automatic t_master();
    wr(CTRL_OFF, 32'h00000003);
    chk("write_resp", bresp_seen, AXI_OKAY);
    settle(1);
    chk("mosi_oe_master", mosi_oe_out, 1'b1);
    chk("miso_oe_master", miso_oe_out, 1'b0);
    chk("sck_oe_master", sck_oe_out, 1'b1);
    chk("routed_3w", select_routed_out, 1'b0);
    far_u.load(8'hA5);
    wr(DATA_OFF, 32'h0000003C);
    wr(DATA_OFF, 32'h000000FF);
    wait_done(d);
    chk("status_master", d[3:0], 4'h5);
    chk("far_rx", far_u.rx_q, 8'h3C);
    rd(DATA_OFF, d, r);
    chk("master_rx", d[7:0], 8'hA5);
    settle(2);
    chk("irq_masked", irq_out, 1'b0);
    wr(IEN_OFF, 32'h00000001);
    settle(2);
    chk("irq_raised", irq_out, 1'b1);
    wr(CLR_OFF, 32'h0000000F);
    settle(2);
    chk("irq_cleared", irq_out, 1'b0);
  endtask

  // both select-output levels of mode 1x
  task automatic t_modes();
    for (int m = 2; m < 4; m++) begin
      wr(CTRL_OFF, {28'h0, m[1:0], 2'h3}); // port and master enabled
      settle(2);
      chk("sel_oe_1x", slave_select_n_oe_out, 1'b1);
      chk("sel_level_1x", slave_select_n_out, m[0]);
    end
  endtask

  task automatic t_fault();
    wr(CTRL_OFF, 32'h00000007);
    settle(2);
    chk("sel_in_01", slave_select_n_oe_out, 1'b0);
    far_u.select(1'b0);
    settle(4);
    chk("fault_release", mosi_oe_out, 1'b0);
    rd(STAT_OFF, d, r);
    chk("fault_flag", d[ST_FAULT], 1'b1);
    rd(CTRL_OFF, d, r);
    chk("fault_enables", d[1:0], 2'h0);
    wr(CLR_OFF, 32'h0000000F);
    far_u.select(1'b1);
  endtask

  // partial byte, ignored clocks while deselected, then a clean byte
  task automatic t_slave4();
    wr(CTRL_OFF, 32'h00000005);
    settle(2);
    chk("miso_unsel", miso_oe_out, 1'b0);
    far_u.select(1'b0);
    settle(1);
    chk("miso_sel", miso_oe_out, 1'b1);
    far_u.xfer(8'h00, 3, rx);
    far_u.select(1'b1);
    far_u.xfer(8'hFF, 5, rx);
    settle(4);
    rd(STAT_OFF, d, r);
    chk("clocks_ignored", d[ST_DONE], 1'b0);
    far_u.select(1'b0);
    far_u.xfer(8'h5A, 8, rx);
    far_u.select(1'b1);
    wait_done(d);
    rd(DATA_OFF, d, r);
    chk("slave_rx", d[7:0], 8'h5A);
    wr(CLR_OFF, 32'h0000000F);
  endtask

  task automatic t_slave3();
    wr(CTRL_OFF, 32'h00000001);
    settle(2);
    chk("miso_3w", miso_oe_out, 1'b1);
    chk("routed_3w_slave", select_routed_out, 1'b0);
    wr(DATA_OFF, 32'h000000C3);
    far_u.xfer(8'h00, 8, rx); // sole slave on the bus
    chk("slave_tx", rx, 8'hC3);
    // unread byte in the buffer: the next one is dropped
    far_u.xfer(8'h81, 8, rx);
    rd(STAT_OFF, d, r);
    chk("overrun_flag", d[3:0], 4'h9);
    rd(DATA_OFF, d, r);
    chk("overrun_keeps", d[7:0], 8'h00);
    wr(CTRL_OFF, 32'h00000000);
    settle(2);
    chk("miso_off", miso_oe_out, 1'b0);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    clk_in = 1'b0;
    reset_in = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_master();
    t_modes();
    t_fault();
    t_slave4();
    t_slave3();
    results();
  end
endmodule

bind sps_core sps_core_properties chk_u (.clk_in, .reset_in,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .sck_out,
  .sck_oe_out, .mosi_out, .mosi_oe_out, .miso_oe_out, .slave_select_n_in,
  .slave_select_n_oe_out, .select_routed_out);
